// ### rtl/pwm_pkg.sv
/*
  Constants, register map and carrier types of the shared-period PWM block.
  Assumes a 32-bit APB master and one system clock.
*/
// Overview of operation
// - Period start drives every enabled output with nonzero duty active
// - Output goes inactive when timebase equals duty
// - Duty beyond period never clears the output
// - Count clears after matching period_limit
// - Zero duty keeps output inactive at boundary
// - Duty copied into buffers at boundary only
// - Duty registers writable anytime, period undisturbed
// - Period is (limit+1) times 4 times prescale
// - Ten-bit timebase: count plus two sub-bits
// - Ratio one advances sub-bits every clock
// - Shared period, independent duty per channel
// - No postscaler influences the output
// - polarity_invert makes the active level low
// - Pin follows port latch unless output enabled
// - Resolution grows with period_limit, ten at 255
// - Sleep freezes counting, state and pin level
// - Reset restores registers, pins set input
// - Status bit mirrors channel output level
package pwm_pkg;
  localparam int NCH = 4;  // Channels on the shared timer
  // Register byte offsets
  localparam logic [7:0] OFS_TB_CTRL = 8'h00;
  localparam logic [7:0] OFS_LIMIT   = 8'h04;
  localparam logic [7:0] OFS_COUNT   = 8'h08;
  localparam logic [7:0] OFS_FLAG    = 8'h0c;
  localparam logic [7:0] OFS_DIR     = 8'h10;
  localparam logic [7:0] OFS_LATCH   = 8'h14;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;  // Channel n at base+16n
  localparam logic [1:0] SUB_CON = 2'h0;       // pwm_control word
  localparam logic [1:0] SUB_DCH = 2'h1;       // duty_high word
  localparam logic [1:0] SUB_DCL = 2'h2;       // duty_low word
  // Field positions
  localparam int RUN_BIT = 0;
  localparam int PRE_LSB = 1;
  localparam int EN_BIT  = 7;
  localparam int OE_BIT  = 6;
  localparam int OUT_BIT = 5;
  localparam int POL_BIT = 4;
  localparam int DCL_LSB = 6;
  // Reset values
  localparam logic [7:0] LIMIT_RST = 8'hff;
  localparam logic [3:0] DIR_RST   = 4'hf;  // All pins input
  // Prescale ratios minus one, selected by timebase_prescale_select
  localparam logic [5:0] PRE_M1_1  = 6'h00;
  localparam logic [5:0] PRE_M1_4  = 6'h03;
  localparam logic [5:0] PRE_M1_16 = 6'h0f;
  localparam logic [5:0] PRE_M1_64 = 6'h3f;
  // Per-channel control bits
  typedef struct packed {
    logic en;   // Channel enable
    logic oe;   // pin_output_enable
    logic pol;  // polarity_invert
  } ctrl_s;
  // Timer control bits
  typedef struct packed {
    logic [1:0] prescale;  // timebase_prescale_select
    logic       run;       // timebase_run
  } tb_ctrl_s;
endpackage : pwm_pkg

// ### rtl/shared_period_pwm_10bit.sv
/*
  Four ten-bit PWM channels sharing one period timer, APB slave.
  Assumes a 32-bit APB master on pclk and an asynchronous sleep request.
*/
`timescale 1ns/10ps
`default_nettype none
module shared_period_pwm_10bit (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic                     sleep_req,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic      [pwm_pkg::NCH-1:0]  pin_o,
  output logic      [pwm_pkg::NCH-1:0]  pin_oe
);
  import pwm_pkg::*;

  ////////////////////////////////////////////////////////////////
  // State
  tb_ctrl_s         tbc_q;              // Timer control
  logic [7:0]       limit_q;            // period_limit
  logic [7:0]       tb_q;               // timebase_count
  logic [1:0]       sub_q;              // Sub-count bits
  logic [5:0]       pre_q;              // Prescale counter
  logic             flag_q;             // timebase_match_flag
  logic [NCH-1:0]   dir_q;              // pin_direction, 1 = input
  logic [NCH-1:0]   latch_q;            // Port data latch
  ctrl_s            ctrl_q [NCH];       // pwm_control
  logic [7:0]       dch_q  [NCH];       // duty_high
  logic [1:0]       dcl_q  [NCH];       // duty_low bits 7:6
  logic [9:0]       dbuf_q [NCH];       // Comparison buffers
  logic [NCH-1:0]   raw_q;              // Unpolarised output
  logic             sleep_m_q;          // Sleep sync stage 1
  logic             sleep_q;            // Sleep sync stage 2
  logic             tick;               // Prescaled step
  logic             boundary;           // Period start
  logic [9:0]       tb_next;            // Extended timebase one step on
  logic             wr_en;              // APB write strobe
  logic [31:0]      rd_d;               // Read mux

  ////////////////////////////////////////////////////////////////
  // Decode helpers
  // Channel window hit
  function automatic logic is_chan(input logic [7:0] a);
    is_chan = (a >= OFS_CH_BASE) && (a[3:2] <= SUB_DCL)
              && (a < OFS_CH_BASE + 8'(16 * NCH))
              && (a[1:0] == 2'h0);
  endfunction : is_chan
  // Channel index of an address
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    logic [7:0] r;
    r = a - OFS_CH_BASE;
    chan_of = r[5:4];
  endfunction : chan_of
  // Prescale terminal count
  function automatic logic [5:0] pre_m1(input logic [1:0] s);
    case (s)
      2'h0:    pre_m1 = PRE_M1_1;
      2'h1:    pre_m1 = PRE_M1_4;
      2'h2:    pre_m1 = PRE_M1_16;
      default: pre_m1 = PRE_M1_64;
    endcase
  endfunction : pre_m1

  ////////////////////////////////////////////////////////////////
  // Sleep request synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_m_q <= 1'b0;
      sleep_q   <= 1'b0;
    end else begin
      sleep_m_q <= sleep_req;
      sleep_q   <= sleep_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB handshake: one wait state
  assign wr_en = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_d;
        // Unmapped address above the latch word answers with an error
        pslverr <= (paddr > OFS_LATCH) && !is_chan(paddr);
      end
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (paddr == OFS_TB_CTRL) begin
      rd_d[RUN_BIT]    = tbc_q.run;
      rd_d[PRE_LSB+:2] = tbc_q.prescale;
    end else if (paddr == OFS_LIMIT) begin
      rd_d[7:0] = limit_q;
    end else if (paddr == OFS_COUNT) begin
      rd_d[7:0] = tb_q;
    end else if (paddr == OFS_FLAG) begin
      rd_d[0] = flag_q;
    end else if (paddr == OFS_DIR) begin
      rd_d[NCH-1:0] = dir_q;
    end else if (paddr == OFS_LATCH) begin
      rd_d[NCH-1:0] = latch_q;
    end else if (is_chan(paddr)) begin
      if (paddr[3:2] == SUB_CON) begin
        rd_d[EN_BIT]  = ctrl_q[chan_of(paddr)].en;
        rd_d[OE_BIT]  = ctrl_q[chan_of(paddr)].oe;
        // Live output level, polarity applied
        rd_d[OUT_BIT] = raw_q[chan_of(paddr)]
                        ^ ctrl_q[chan_of(paddr)].pol;
        rd_d[POL_BIT] = ctrl_q[chan_of(paddr)].pol;
      end else if (paddr[3:2] == SUB_DCH) begin
        rd_d[7:0] = dch_q[chan_of(paddr)];
      end else begin
        rd_d[DCL_LSB+:2] = dcl_q[chan_of(paddr)];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Software registers; duty writes never touch buffers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin  // All registers to defaults
      tbc_q   <= '0;
      limit_q <= LIMIT_RST;
      dir_q   <= DIR_RST;  // Pins input after reset
      latch_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= '0;
        dch_q[i]  <= 8'h00;
        dcl_q[i]  <= 2'h0;
      end
    end else if (wr_en) begin
      if (paddr == OFS_TB_CTRL) begin
        tbc_q <= {pwdata[PRE_LSB+:2], pwdata[RUN_BIT]};
      end else if (paddr == OFS_LIMIT) begin
        limit_q <= pwdata[7:0];
      end else if (paddr == OFS_DIR) begin
        dir_q <= pwdata[NCH-1:0];
      end else if (paddr == OFS_LATCH) begin
        latch_q <= pwdata[NCH-1:0];
      end else if (is_chan(paddr)) begin
        if (paddr[3:2] == SUB_CON) begin
          ctrl_q[chan_of(paddr)] <= {pwdata[EN_BIT],
            pwdata[OE_BIT], pwdata[POL_BIT]};
        end else if (paddr[3:2] == SUB_DCH) begin
          dch_q[chan_of(paddr)] <= pwdata[7:0];
        end else begin
          dcl_q[chan_of(paddr)] <= pwdata[DCL_LSB+:2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shared timebase; no postscaler in this path
  // Ratio one gives a tick every clock
  // A count left above a smaller new ratio ends at once, no wrap
  assign tick = tbc_q.run && !sleep_q
                && (pre_q >= pre_m1(tbc_q.prescale));
  // Next extended value, so the output falls as the match begins
  assign tb_next = {tb_q, sub_q} + 10'h001;
  // Last sub-step of the limit count
  assign boundary = tick && (sub_q == 2'h3) && (tb_q == limit_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
      sub_q <= 2'h0;
      tb_q  <= 8'h00;
    end else if (wr_en && paddr == OFS_COUNT) begin
      tb_q <= pwdata[7:0];
    end else if (tbc_q.run && !sleep_q) begin  // Frozen in sleep
      pre_q <= tick ? 6'h00 : pre_q + 6'h01;
      if (tick) begin
        sub_q <= sub_q + 2'h1;  // Sub-bits extend count
        if (sub_q == 2'h3) begin
          tb_q <= boundary ? 8'h00 : tb_q + 8'h01;
        end
      end
    end
  end

  // Match flag; a boundary beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= boundary || (flag_q
                && !(wr_en && paddr == OFS_FLAG && pwdata[0]));
    end
  end

  ////////////////////////////////////////////////////////////////
  // Channels: shared period, own duty each
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // Buffer load only at period start
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dbuf_q[i] <= 10'h000;
      end else if (boundary) begin
        dbuf_q[i] <= {dch_q[i], dcl_q[i]};
      end
    end
    // Output state; frozen while sleeping
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        raw_q[i] <= 1'b0;
      end else if (!ctrl_q[i].en) begin
        raw_q[i] <= 1'b0;
      end else if (boundary) begin
        // Active unless new duty is zero
        raw_q[i] <= ({dch_q[i], dcl_q[i]} != 10'h000);
      end else if (tick && tb_next == dbuf_q[i]) begin
        // Never reached when duty exceeds period
        raw_q[i] <= 1'b0;
      end
    end
    // Pin mux and driver enable
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_o[i]  <= 1'b0;
        pin_oe[i] <= 1'b0;
      end else begin
        pin_oe[i] <= !dir_q[i];
        pin_o[i]  <= ctrl_q[i].oe ? (raw_q[i] ^ ctrl_q[i].pol)
                                  : latch_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks on channel 0 and the timebase
  sequence s_bound_ok;
    boundary && ctrl_q[0].en && ({dch_q[0], dcl_q[0]} != 10'h000);
  endsequence
  sequence s_match;
    ctrl_q[0].en && !boundary && tick
      && (tb_next == dbuf_q[0]);
  endsequence
  property p_start_active;
    @(posedge pclk) disable iff (!presetn) s_bound_ok |=> raw_q[0];
  endproperty
  a_start_active: assert property (p_start_active)
    else $error("output not active at period start");
  property p_match_clear;
    @(posedge pclk) disable iff (!presetn) s_match |=> !raw_q[0];
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("output not cleared at duty match");
  property p_zero_duty;
    @(posedge pclk) disable iff (!presetn)
      boundary && ({dch_q[0], dcl_q[0]} == 10'h000) |=> !raw_q[0];
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("zero duty went active");
  property p_count_clear;
    @(posedge pclk) disable iff (!presetn)
      boundary && !(wr_en && paddr == OFS_COUNT)
      |=> tb_q == 8'h00 && sub_q == 2'h0 && flag_q;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("count not cleared after limit match");
  property p_buf_hold;
    @(posedge pclk) disable iff (!presetn)
      !boundary |=> $stable(dbuf_q[0]);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("duty buffer changed off boundary");
  property p_sleep_freeze;
    @(posedge pclk) disable iff (!presetn)
      sleep_q && !wr_en ##1 sleep_q
      |-> $stable(tb_q) && $stable(raw_q) && $stable(sub_q);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("state moved during sleep");
  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[0].oe && $stable(ctrl_q[0])
      |=> pin_o[0] == ($past(raw_q[0]) ^ $past(ctrl_q[0].pol));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pin level ignores polarity");
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_q[0].en |=> !raw_q[0];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled channel output active");
  property p_ratio_one;
    @(posedge pclk) disable iff (!presetn)
      tbc_q.run && tbc_q.prescale == 2'h0 && !sleep_q |-> tick;
  endproperty
  a_ratio_one: assert property (p_ratio_one)
    else $error("ratio one does not step every clock");
endmodule : shared_period_pwm_10bit
`default_nettype wire

// ### verif/pwm_load.sv
/*
  Load on the four PWM pins: pulled-down line, high-time and rising-edge counts.
  Assumes pin_o and pin_oe come from the PWM block and everything runs on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module pwm_load (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clr,
  input  wire logic [pwm_pkg::NCH-1:0]       pin_o,
  input  wire logic [pwm_pkg::NCH-1:0]       pin_oe,
  output logic      [pwm_pkg::NCH-1:0]       line,
  output logic      [pwm_pkg::NCH-1:0][15:0] hi_cnt,
  output logic      [pwm_pkg::NCH-1:0][15:0] rise_cnt
);
  import pwm_pkg::*;
  logic [NCH-1:0] prev_q;  // Line level one cycle back
  ////////////////////////////////////////////////////////////
  // Released pin falls to the pull-down level
  assign line = pin_o & pin_oe;
  // Counters of high cycles and rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q   <= '0;
      hi_cnt   <= '0;
      rise_cnt <= '0;
    end else begin
      prev_q <= line;
      for (int i = 0; i < NCH; i++) begin
        if (clr) begin  // Start of a window
          hi_cnt[i]   <= 16'h0;
          rise_cnt[i] <= 16'h0;
        end else begin  // Count inside the window
          hi_cnt[i]   <= hi_cnt[i] + 16'(line[i]);
          rise_cnt[i] <= rise_cnt[i] + 16'(line[i] & ~prev_q[i]);
        end
      end
    end
  end
endmodule : pwm_load
`default_nettype wire

// ### verif/test_shared_period_pwm_10bit.sv
/*
  Self-checking bench: APB master, pin load, random duties and corner cases.
  Assumes the package, the PWM block and the load model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_shared_period_pwm_10bit;
  import pwm_pkg::*;
  logic                     pclk, presetn, psel, penable, pwrite, sleep_req, pready, pslverr, clr, err;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd, keep;
  logic [NCH-1:0]           pin_o, pin_oe, line, pol, lv;
  logic [NCH-1:0][15:0]     hi_cnt, rise_cnt;
  int                       error_cnt = 0, num_checks = 0, cyc = 0, lim;
  int                       d [NCH];
  ////////////////////////////////////////////////////////////
  shared_period_pwm_10bit i_shared_period_pwm_10bit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sleep_req(sleep_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_o(pin_o), .pin_oe(pin_oe));
  pwm_load i_pwm_load (.pclk(pclk), .presetn(presetn), .clr(clr), .pin_o(pin_o), .pin_oe(pin_oe),
    .line(line), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));
  // Clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends on pready; only the hang guard bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Channel word address
  function automatic logic [7:0] adr(input int c, input logic [1:0] sub);
    adr = OFS_CH_BASE + 8'(16 * c) + 8'({sub, 2'b00});
  endfunction : adr
  // Control word of a channel
  task automatic con_wr(input int c, input logic en, input logic oe);
    apb(1'b1, adr(c, SUB_CON), {24'h0, en, oe, 1'b0, pol[c], 4'h0});
  endtask : con_wr
  // Both duty halves
  task automatic duty_wr(input int c, input logic [9:0] v);
    apb(1'b1, adr(c, SUB_DCH), {24'h0, v[9:2]});
    apb(1'b1, adr(c, SUB_DCL), {24'h0, v[1:0], 6'h0});
  endtask : duty_wr
  // Ordered start-up, then settle two periods
  task automatic setup(input int l, input logic [1:0] sel);
    int n;
    apb(1'b1, OFS_DIR, 32'hf);
    for (int c = 0; c < NCH; c++) con_wr(c, 1'b0, 1'b0);
    apb(1'b1, OFS_LIMIT, 32'(l));
    for (int c = 0; c < NCH; c++) duty_wr(c, 10'h0);
    apb(1'b1, OFS_FLAG, 32'h1);
    apb(1'b1, OFS_TB_CTRL, {29'h0, sel, 1'b0});
    apb(1'b1, OFS_TB_CTRL, {29'h0, sel, 1'b1});
    n = 0;
    do begin
      apb(1'b0, OFS_FLAG, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 600);
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b1, OFS_DIR, 32'h0);
    for (int c = 0; c < NCH; c++) duty_wr(c, 10'(d[c]));
    for (int c = 0; c < NCH; c++) con_wr(c, 1'b1, 1'b1);
    repeat (8 * (l + 1) * (1 << (2 * sel))) @(posedge pclk);
  endtask : setup
  // Count over four whole periods, then check each channel
  task automatic measure(input int l, input int r);
    int p;
    int h;
    p = (l + 1) * 4 * r;
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (4 * p) @(posedge pclk);
    #1;
    for (int c = 0; c < NCH; c++) begin
      h = (d[c] >= 4 * (l + 1)) ? p : d[c] * r;
      chk({16'h0, hi_cnt[c]}, 32'(4 * (pol[c] ? p - h : h)));
      chk({16'h0, rise_cnt[c]}, (h == 0 || h == p) ? 32'h0 : 32'h4);
    end
  endtask : measure
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, sleep_req, clr, presetn} = 6'h0;
    paddr  = 8'h0;
    pwdata = 32'h0;
    pol    = 4'h0;
    void'($urandom(72436));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_LIMIT, 32'h0);
    chk(rd, {24'h0, LIMIT_RST});
    apb(1'b0, OFS_DIR, 32'h0);
    chk(rd, {28'h0, DIR_RST});
    chk({28'h0, pin_oe}, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk({rd[30:0], err}, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // Random limit and duties: partial, zero, full-on, inverted
    lim  = 3 + $urandom % 13;
    d[0] = 1 + $urandom % (4 * lim + 3);
    d[1] = 0;
    d[2] = 4 * lim + 4 + $urandom % 100;
    d[3] = 1 + $urandom % (4 * lim + 3);
    pol  = 4'h8;
    setup(lim, 2'h0);
    measure(lim, 1);
    apb(1'b0, adr(2, SUB_CON), 32'h0);
    chk(rd, 32'he0);
    apb(1'b0, adr(1, SUB_CON), 32'h0);
    chk(rd, 32'hc0);
    // New duty written mid-run
    d[0] = 4 * lim + 3;
    duty_wr(0, 10'(d[0]));
    repeat (8 * (lim + 1)) @(posedge pclk);
    measure(lim, 1);
    // Sleep freezes count and pins
    sleep_req <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_COUNT, 32'h0);
    keep = rd;
    lv   = line;
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd, keep);
    chk({28'h0, line}, {28'h0, lv});
    sleep_req <= 1'b0;
    // Disabled channel stays inactive
    con_wr(0, 1'b0, 1'b1);
    d[0] = 0;
    repeat (8 * (lim + 1)) @(posedge pclk);
    measure(lim, 1);
    // Pin handed to the port latch, then to input
    apb(1'b1, OFS_LATCH, 32'h1);
    con_wr(0, 1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, pin_o[0]}, 32'h1);
    apb(1'b1, OFS_DIR, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, pin_oe[0]}, 32'h0);
    // Every prescale code at limit 3
    d   = '{5, 0, 16, 12};
    pol = 4'h0;
    for (int s = 0; s < 4; s++) begin
      setup(3, 2'(s));
      measure(3, 1 << (2 * s));
    end
    // Reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({28'h0, pin_oe}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, OFS_LIMIT, 32'h0);
    chk(rd, {24'h0, LIMIT_RST});
    wrap_up();
  end
endmodule : test_shared_period_pwm_10bit
`default_nettype wire
